// ---- rtl/vbuf_cfg_defs.vh ----
// Purpose: constants for the video buffer two-wire configuration slave
// Assumes: 50 MHz system clock
// Notes:   channel subaddress codes 1 to 3 select register indices 0 to 2
`ifndef VBUF_CFG_DEFS_VH
`define VBUF_CFG_DEFS_VH
`define ADDR_FIXED_BITS   5'b01011
`define SUB_CHANNEL_1     8'h01
`define SUB_CHANNEL_2     8'h02
`define SUB_CHANNEL_3     8'h03
`define CHANNEL_COUNT     3
`define FLD_CLAMP_MSB     7
`define FLD_CLAMP_LSB     6
`define FLD_MUX_BIT       5
`define FLD_LPF_MSB       4
`define FLD_LPF_LSB       3
`define FLD_BIAS_MSB      2
`define FLD_BIAS_LSB      0
`define DIR_WRITE         1'b0
`define DIR_READ          1'b1
`define CLK_PERIOD_NS     20
// extra clocks of data hold after synced SCL fall; sync delay already gives some
`define HOLD_CYCLES       6'd0
`endif

// ---- rtl/chan_reg_file.v ----
// Purpose: three byte channel configuration store, registered read port
// Assumes: single clock, one write per cycle
// Notes:   contents have no reset value on purpose
`timescale 1ns/1ps
`default_nettype none
module chan_reg_file #(
  parameter DEPTH = 3
) (
  // clock
  input  wire       clk,
  // write port
  input  wire       wr_en,
  input  wire [1:0] wr_idx,
  input  wire [7:0] wr_data,
  // read port
  input  wire [1:0] rd_idx,
  output reg  [7:0] rd_data
);
  reg [7:0] mem [0:DEPTH-1];

  // no reset: power-up contents arbitrary
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule
`default_nettype wire

// ---- rtl/vbuf_i2c_slave.v ----
// Purpose: two-wire slave holding three channel configuration bytes
// Assumes: clk 50 MHz, bus lines oversampled, master drives all clocks
// Notes:   one data byte per transfer; registers power up arbitrary
`timescale 1ns/1ps
`default_nettype none
`include "vbuf_cfg_defs.vh"

module vbuf_i2c_slave (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // two-wire bus, open drain
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // address select pins
  input  wire       addr_select_upper_pin,
  input  wire       addr_select_lower_pin,
  // channel fields
  output reg  [1:0] ch1_tip_clamp_filter_select,
  output reg        ch1_input_mux_select,
  output reg  [1:0] ch1_lowpass_select,
  output reg  [2:0] ch1_bias_mode,
  output reg  [1:0] ch2_tip_clamp_filter_select,
  output reg        ch2_input_mux_select,
  output reg  [1:0] ch2_lowpass_select,
  output reg  [2:0] ch2_bias_mode,
  output reg  [1:0] ch3_tip_clamp_filter_select,
  output reg        ch3_input_mux_select,
  output reg  [1:0] ch3_lowpass_select,
  output reg  [2:0] ch3_bias_mode
);
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_ADDR   = 3'd1;
  localparam [2:0] ST_SUB    = 3'd2;
  localparam [2:0] ST_DATA   = 3'd3;
  localparam [2:0] ST_TX     = 3'd4;
  localparam [2:0] ST_ACK    = 3'd5;
  localparam [2:0] ST_RXACK  = 3'd6;
  localparam [2:0] ST_IGNORE = 3'd7;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  reg       scl_m;
  reg       scl_s;
  reg       scl_d;
  reg       sda_m;
  reg       sda_s;
  reg       sda_d;
  reg       sel_hi_m;
  reg       sel_hi_s;
  reg       sel_lo_m;
  reg       sel_lo_s;

  // oversampled far above bus rate, two stages before use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_m    <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_m    <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
      sel_hi_m <= 1'b0;
      sel_hi_s <= 1'b0;
      sel_lo_m <= 1'b0;
      sel_lo_s <= 1'b0;
    end else begin
      scl_m    <= scl_in;
      scl_s    <= scl_m;
      scl_d    <= scl_s;
      sda_m    <= sda_in;
      sda_s    <= sda_m;
      sda_d    <= sda_s;
      sel_hi_m <= addr_select_upper_pin;
      sel_hi_s <= sel_hi_m;
      sel_lo_m <= addr_select_lower_pin;
      sel_lo_s <= sel_lo_m;
    end
  end

  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine
  reg [2:0] state;
  reg [2:0] ack_next;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [1:0] sub_idx;
  reg       sub_valid;
  reg       wr_en;
  reg [1:0] wr_idx;
  reg [7:0] wr_data;
  reg [5:0] hold_cnt;
  reg       sda_pend;
  reg       sda_pend_val;
  wire [7:0] rd_data;

  // fixed bits then live pin levels
  wire [6:0] own_addr = {`ADDR_FIXED_BITS, sel_hi_s, sel_lo_s};

  function [1:0] sub_decode;
    input [7:0] code;
    begin
      if (code == `SUB_CHANNEL_1) begin
        sub_decode = 2'd0;
      end else if (code == `SUB_CHANNEL_2) begin
        sub_decode = 2'd1;
      end else begin
        sub_decode = 2'd2;
      end
    end
  endfunction

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      ack_next     <= ST_IGNORE;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      sub_idx      <= 2'd0;
      sub_valid    <= 1'b0;
      wr_en        <= 1'b0;
      wr_idx       <= 2'd0;
      wr_data      <= 8'h00;
      sda_pend     <= 1'b0;
      sda_pend_val <= 1'b0;
      hold_cnt     <= 6'h00;
      sda_out      <= 1'b0;
      sda_oe       <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      // SDA changes a hold time after SCL falls, so only while low
      if (sda_pend) begin
        if (hold_cnt == 6'h00) begin
          sda_pend <= 1'b0;
          sda_oe   <= sda_pend_val;
        end else begin
          hold_cnt <= hold_cnt - 6'h01;
        end
      end
      if (start_seen) begin
        // first byte after any start is address
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_pend <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop_seen) begin
        state    <= ST_IDLE;  // release bus
        sda_pend <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_SUB, ST_DATA: begin
            shift   <= {shift[6:0], sda_s};  // msb first
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_TX: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RXACK: begin
            // nack or ack: one byte only, then ignore
            state <= ST_IGNORE;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_IDLE: begin
            // stray clock clears any stuck drive
            sda_pend <= 1'b0;
            sda_oe   <= 1'b0;
          end
          ST_ADDR: begin
            if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (shift[7:1] == own_addr) begin
                sda_pend     <= 1'b1;  // acknowledge on match
                sda_pend_val <= 1'b1;
                hold_cnt     <= `HOLD_CYCLES;
                state        <= ST_ACK;
                if (shift[0] == `DIR_READ) begin
                  ack_next <= ST_TX;
                end else begin
                  ack_next <= ST_SUB;
                end
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_SUB, ST_DATA: begin
            if (bit_cnt == 4'h8) begin
              bit_cnt      <= 4'h0;
              sda_pend     <= 1'b1;
              sda_pend_val <= 1'b1;
              hold_cnt     <= `HOLD_CYCLES;
              state        <= ST_ACK;
              if (state == ST_SUB) begin
                // subaddress kept for a later read
                sub_valid <= (shift == `SUB_CHANNEL_1) || (shift == `SUB_CHANNEL_2) ||
                             (shift == `SUB_CHANNEL_3);
                sub_idx   <= sub_decode(shift);
                ack_next  <= ST_DATA;
              end else begin
                // one data byte only, invalid subaddress ignored
                wr_en    <= sub_valid;
                wr_idx   <= sub_idx;
                wr_data  <= shift;
                ack_next <= ST_IGNORE;
              end
            end
          end
          ST_ACK: begin
            if (ack_next == ST_TX) begin
              shift        <= {rd_data[6:0], 1'b0};  // selected register
              sda_pend     <= 1'b1;
              sda_pend_val <= ~rd_data[7];
              hold_cnt     <= `HOLD_CYCLES;
              bit_cnt      <= 4'h1;
            end else begin
              sda_pend     <= 1'b1;  // release after ack clock
              sda_pend_val <= 1'b0;
              hold_cnt     <= `HOLD_CYCLES;
              bit_cnt      <= 4'h0;
            end
            state <= ack_next;
          end
          ST_TX: begin
            sda_pend <= 1'b1;
            hold_cnt <= `HOLD_CYCLES;
            // count starts at 1, so 9 means all eight bits went out
            if (bit_cnt == 4'h9) begin
              sda_pend_val <= 1'b0;  // free line for master ack
              state        <= ST_RXACK;
            end else begin
              sda_pend_val <= ~shift[7];  // low only, open drain
              shift        <= {shift[6:0], 1'b0};
            end
          end
          default: begin
          end
        endcase
      end
      // sda_out fixed low: line only pulled low
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel store and field outputs
  chan_reg_file #(
    .DEPTH (`CHANNEL_COUNT)
  ) u_regs (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (sub_idx),
    .rd_data (rd_data)
  );

  // field outputs straight from flops, no reset
  always @(posedge clk) begin
    if (wr_en && wr_idx == 2'd0) begin
      ch1_tip_clamp_filter_select <= wr_data[`FLD_CLAMP_MSB:`FLD_CLAMP_LSB];
      ch1_input_mux_select        <= wr_data[`FLD_MUX_BIT];
      ch1_lowpass_select          <= wr_data[`FLD_LPF_MSB:`FLD_LPF_LSB];
      ch1_bias_mode               <= wr_data[`FLD_BIAS_MSB:`FLD_BIAS_LSB];
    end
    if (wr_en && wr_idx == 2'd1) begin
      ch2_tip_clamp_filter_select <= wr_data[`FLD_CLAMP_MSB:`FLD_CLAMP_LSB];
      ch2_input_mux_select        <= wr_data[`FLD_MUX_BIT];
      ch2_lowpass_select          <= wr_data[`FLD_LPF_MSB:`FLD_LPF_LSB];
      ch2_bias_mode               <= wr_data[`FLD_BIAS_MSB:`FLD_BIAS_LSB];
    end
    if (wr_en && wr_idx == 2'd2) begin
      ch3_tip_clamp_filter_select <= wr_data[`FLD_CLAMP_MSB:`FLD_CLAMP_LSB];
      ch3_input_mux_select        <= wr_data[`FLD_MUX_BIT];
      ch3_lowpass_select          <= wr_data[`FLD_LPF_MSB:`FLD_LPF_LSB];
      ch3_bias_mode               <= wr_data[`FLD_BIAS_MSB:`FLD_BIAS_LSB];
    end
  end

  // SCL never driven; slave only listens
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/vbuf_i2c_props.sv ----
// Purpose: bus-level checks on the configuration slave
// Assumes: bus pins seen as resolved open-drain levels
// Notes:   helper tracks bit count and captured bytes
`timescale 1ns/1ps
`default_nettype none
`include "vbuf_cfg_defs.vh"
module vbuf_i2c_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // address pins and channel one fields
  input wire logic       addr_select_upper_pin,
  input wire logic       addr_select_lower_pin,
  input wire logic [1:0] ch1_tip_clamp_filter_select,
  input wire logic       ch1_input_mux_select,
  input wire logic [1:0] ch1_lowpass_select,
  input wire logic [2:0] ch1_bias_mode
);
  logic       scl_q, sda_q, miss, rw;
  logic [5:0] bitcnt;
  logic [8:0] sh;
  logic [7:0] sub;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_q, sda_q, miss, rw} <= 4'hE;
      bitcnt <= 6'h00;
      sh <= 9'h000;
      sub <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_in && scl_q && sda_q != sda_in) begin
        // start clears, stop idles
        bitcnt <= 6'h00;
        miss <= sda_in;
      end else if (scl_in && !scl_q) begin
        bitcnt <= bitcnt + 6'h01;
        sh <= {sh[7:0], sda_in};
      end else if (!scl_in && scl_q && bitcnt == 6'h08) begin
        miss <= sh[7:1] != {`ADDR_FIXED_BITS, addr_select_upper_pin, addr_select_lower_pin};
        rw <= sh[0];
      end else if (!scl_in && scl_q && bitcnt == 6'h11) begin
        sub <= sh[7:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_addr_hit;
    $fell(scl_in) && bitcnt == 6'h08 &&
      sh[7:1] == {`ADDR_FIXED_BITS, addr_select_upper_pin, addr_select_lower_pin};
  endsequence
  sequence s_ack_fall;
    $fell(scl_in) && bitcnt != 6'h00 && bitcnt % 6'h09 == 6'h00 && !rw && !miss;
  endsequence
  property p_scl_free; scl_oe == 1'b0; endproperty
  property p_no_high; sda_out == 1'b0; endproperty
  property p_drive_low; $rose(sda_oe) |-> !scl_in; endproperty
  property p_steady; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  property p_ack_hit; s_addr_hit |-> ##[1:6] sda_oe; endproperty
  property p_ignore; miss |-> !sda_oe; endproperty
  property p_ack_end; s_ack_fall |-> ##[1:6] !sda_oe; endproperty
  property p_one_byte; scl_in && bitcnt == 6'h24 && !rw |-> !sda_oe; endproperty
  property p_store;
    $fell(scl_in) && bitcnt == 6'h1B && !rw && !miss && sub == 8'h01 |->
      {ch1_tip_clamp_filter_select, ch1_input_mux_select, ch1_lowpass_select,
       ch1_bias_mode} == sh[8:1];
  endproperty
  a_scl_free: assert property (p_scl_free) else $error("scl driven");
  a_no_high: assert property (p_no_high) else $error("sda driven high");
  a_drive_low: assert property (p_drive_low) else $error("sda taken in high");
  a_steady: assert property (p_steady) else $error("sda moved in high");
  a_ack_hit: assert property (p_ack_hit) else $error("no address ack");
  a_ignore: assert property (p_ignore) else $error("foreign ack");
  a_ack_end: assert property (p_ack_end) else $error("ack not released");
  a_one_byte: assert property (p_one_byte) else $error("extra byte acked");
  a_store: assert property (p_store) else $error("channel not stored");
endmodule
bind vbuf_i2c_slave vbuf_i2c_props u_props (.clk, .rst_b, .scl_in, .sda_in, .scl_oe,
  .sda_out, .sda_oe, .addr_select_upper_pin, .addr_select_lower_pin,
  .ch1_tip_clamp_filter_select, .ch1_input_mux_select, .ch1_lowpass_select, .ch1_bias_mode);
`default_nettype wire

// ---- sim/two_wire_master.sv ----
// Purpose: two-wire bus master model
// Assumes: pulls lines low or releases them, pull-ups elsewhere
// Notes:   bit period 160 ns: five clocks low, three high
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
  // clock and bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HI  = 3;
  localparam int LO  = 5;
  localparam int SET = 2;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    repeat (SET) @(negedge clk);
    sda_low = !b;
    repeat (LO - SET) @(negedge clk);
    scl_low = 1'b0;
    repeat (HI) @(negedge clk);
    r = sda;
    scl_low = 1'b1;
  endtask
  task automatic start;
    repeat (LO) @(negedge clk);
    sda_low = 1'b1;
    repeat (HI) @(negedge clk);
    scl_low = 1'b1;
  endtask
  task automatic stop;
    repeat (SET) @(negedge clk);
    sda_low = 1'b1;
    repeat (LO - SET) @(negedge clk);
    scl_low = 1'b0;
    repeat (HI) @(negedge clk);
    sda_low = 1'b0;
    repeat (LO) @(negedge clk);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
endmodule
`default_nettype wire

// ---- sim/video_buffer_i2c_config_slave_test.sv ----
// Purpose: self-checking bench for the configuration slave
// Assumes: 50 MHz clock, master model on the bus
// Notes:   fields checked as whole register bytes
`timescale 1ns/1ps
`default_nettype none
`include "vbuf_cfg_defs.vh"
module video_buffer_i2c_config_slave_test;
  logic       clk, rst_b, a_hi, a_lo;
  logic [7:0] got;
  logic [7:0] pat [1:3] = '{8'hF5, 8'h2A, 8'h93};
  int         miscompares, checked;
  wire        scl_oe, scl_out, sda_oe, sda_out, m_scl, m_sda;
  // open drain: pulled up unless a side pulls low
  wire        scl = !m_scl && (scl_oe ? scl_out : 1'b1);
  wire        sda = !m_sda && (sda_oe ? sda_out : 1'b1);
  wire  [1:0] t1, t2, t3, l1, l2, l3;
  wire  [2:0] b1, b2, b3;
  wire        x1, x2, x3;
  wire  [7:0] ch [1:3];
  assign ch[1] = {t1, x1, l1, b1};
  assign ch[2] = {t2, x2, l2, b2};
  assign ch[3] = {t3, x3, l3, b3};
  vbuf_i2c_slave uut (.clk, .rst_b, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out,
    .sda_oe, .addr_select_upper_pin(a_hi), .addr_select_lower_pin(a_lo),
    .ch1_tip_clamp_filter_select(t1), .ch1_input_mux_select(x1), .ch1_lowpass_select(l1),
    .ch1_bias_mode(b1), .ch2_tip_clamp_filter_select(t2), .ch2_input_mux_select(x2),
    .ch2_lowpass_select(l2), .ch2_bias_mode(b2), .ch3_tip_clamp_filter_select(t3),
    .ch3_input_mux_select(x3), .ch3_lowpass_select(l3), .ch3_bias_mode(b3));
  two_wire_master m (.clk, .sda, .scl_low(m_scl), .sda_low(m_sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task put(input logic [7:0] b, input logic e);
    logic ack;
    m.send(b, ack);
    check({7'h00, ack}, {7'h00, e});
  endtask
  function logic [7:0] dev(input logic rd);
    return {`ADDR_FIXED_BITS, a_hi, a_lo, rd};
  endfunction
  task wr(input logic [7:0] s, input logic [7:0] d);
    m.start;
    put(dev(`DIR_WRITE), 1'b1);
    put(s, 1'b1);
    put(d, 1'b1);
    m.stop;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task test_write;
    for (int n = 1; n <= 3; n++) wr(n[7:0], pat[n]);
    for (int n = 1; n <= 3; n++) check(ch[n], pat[n]);
    $display("test write done");
  endtask
  task test_read;
    for (int n = 3; n >= 1; n--) begin
      m.start;
      put(dev(`DIR_WRITE), 1'b1);
      put(n[7:0], 1'b1);
      m.stop;
      m.start;
      put(dev(`DIR_READ), 1'b1);
      m.recv(got);
      m.stop;
      check(got, pat[n]);
    end
    $display("test read done");
  endtask
  task test_pins;
    {a_hi, a_lo} = 2'b10;
    m.start;
    put({`ADDR_FIXED_BITS, 3'h2}, 1'b0);
    m.stop;
    m.start;
    put(8'h5A, 1'b0);
    m.stop;
    pat[1] = 8'h0C;
    wr(`SUB_CHANNEL_1, pat[1]);
    check(ch[1], pat[1]);
    $display("test pins done");
  endtask
  task test_refuse;
    wr(8'h05, 8'hFF);
    wr(8'h00, 8'hFF);
    for (int n = 1; n <= 3; n++) check(ch[n], pat[n]);
    m.start;
    put(dev(`DIR_WRITE), 1'b1);
    put(`SUB_CHANNEL_2, 1'b1);
    put(8'h11, 1'b1);
    put(8'h22, 1'b0);
    m.stop;
    check(ch[2], 8'h11);
    $display("test refuse done");
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    {a_hi, a_lo} = 2'b01;
    miscompares = 0;
    checked = 0;
    repeat (6) @(negedge clk);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    test_write;
    test_read;
    test_pins;
    test_refuse;
    give_verdict;
  end
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
